// [inc/pcp_pkg.sv]
// constants, pin layout, register map and types of the processor bus capture pod
package pcp_pkg;

  // ---------------------------------------------------------------
  // sample word layout
  // ---------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int DATA_LSB = 0;     // data byte, inputs 0-7
  localparam int ADDR_LSB = 8;     // address, inputs 8-23
  localparam int STATUS_LSB = 24;  // cycle status, inputs 24-27
  localparam int SPARE_LSB = 28;   // side inputs, 28-31
  localparam int CTL_ADDR_W = 12;  // controller families use inputs 8-19 only

  // ---------------------------------------------------------------
  // pin vector layout, as seen by the synchroniser
  // ---------------------------------------------------------------
  localparam int PIN_AD = 0;       // 8 bits, data or multiplexed low address
  localparam int PIN_A = 8;        // 16 bits, address pins
  localparam int PIN_ALE = 24;
  localparam int PIN_RD_N = 25;
  localparam int PIN_WR_N = 26;
  localparam int PIN_INTA_N = 27;
  localparam int PIN_STAT_LO = 28;
  localparam int PIN_STAT_HI = 29;
  localparam int PIN_IOM = 30;
  localparam int PIN_HOLD = 31;
  localparam int PIN_PSTORE_N = 32;
  localparam int PIN_EXP_N = 33;
  localparam int PIN_BUS_EN = 34;
  localparam int PIN_PHI2 = 35;
  localparam int PIN_RW = 36;
  localparam int PIN_HALT = 37;
  localparam int PIN_VMA = 38;
  localparam int PIN_BA = 39;
  localparam int PIN_SPARE = 40;   // 4 bits
  localparam int PIN_W = 44;
  // idle level of every pin: active-low strobes and read/write sit high
  localparam logic [PIN_W-1:0] PIN_IDLE = 44'h013_0E00_0000;

  // ---------------------------------------------------------------
  // register map (byte addresses) and fields
  // ---------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [REG_AW-1:0] REG_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h04;
  localparam logic [REG_AW-1:0] REG_SAMPLE = 8'h08;
  localparam logic [REG_AW-1:0] REG_TRIG_VAL = 8'h0C;
  localparam logic [REG_AW-1:0] REG_TRIG_MASK = 8'h10;
  localparam logic [REG_AW-1:0] REG_COUNT = 8'h14;
  localparam int CTRL_W = 6;
  localparam int CTRL_FAM_LSB = 0;   // 2 bits, processor family
  localparam int CTRL_WSEL = 2;      // write edge: 0 phase-two fall, 1 bus enable fall
  localparam int CTRL_FREE = 3;      // 1 = one sample per reference clock
  localparam int CTRL_CAP_EN = 4;
  localparam int CTRL_SPARE_EN = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h30;   // synchronous capture, on
  localparam int STAT_HIT = 0;
  localparam logic [WORD_W-1:0] TRIG_VAL_RST = 32'h0000_0000;
  localparam logic [WORD_W-1:0] TRIG_MASK_RST = 32'h0000_0000;
  localparam int COUNT_W = 16;

  // processor family served by the pod
  typedef enum logic [1:0] {
    PCP_FAM_MUX,        // multiplexed bus processor
    PCP_FAM_CTL_EXP,    // controller with port-expander strobe
    PCP_FAM_CTL,        // controller without expander or i/o code
    PCP_FAM_NOCLK       // variant clocked from phase two and bus enable
  } pcp_family_t;

endpackage

// [inc/pcp_pin_if.sv]
// synchronised pin vector passed from the synchroniser to the capture logic
`timescale 1ns/1ns
interface pcp_pin_if;
  logic [pcp_pkg::PIN_W-1:0] now;   // pins after two flip-flops
  logic [pcp_pkg::PIN_W-1:0] prev;  // one cycle older, for edges and data
  modport sync_side (output now, output prev);
  modport user_side (input now, input prev);
endinterface

// [verilog/pcp_pin_sync.sv]
// three-stage pin synchroniser: two flops for metastability, one for edge history
`timescale 1ns/1ns
module pcp_pin_sync
  import pcp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // raw target pins
  input wire logic [pcp_pkg::PIN_W-1:0] pins,
  // synchronised view
  pcp_pin_if.sync_side pin_bus
);

  // ---------------------------------------------------------------
  // per-bit flop chain
  // ---------------------------------------------------------------
  for (genvar i = 0; i < PIN_W; i++) begin : g_bit
    logic meta_r;   // first stage, read only by the second
    logic now_r;
    logic prev_r;
    // reset to the idle level so no false edge shows after release
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        meta_r <= PIN_IDLE[i];
        now_r <= PIN_IDLE[i];
        prev_r <= PIN_IDLE[i];
      end else begin
        meta_r <= pins[i];
        now_r <= meta_r;
        prev_r <= now_r;
      end
    end
    assign pin_bus.now[i] = now_r;
    assign pin_bus.prev[i] = prev_r;
  end

endmodule

// [verilog/pcp_capture_pod.sv]
// capture front end turning target processor bus cycles into 32-bit sample words
//
// Notes on behaviour
// - data byte lands on sample bits 0-7
// - address on bits 8-23, controllers 8-19
// - bits 24-31 carry status and spare lines
// - bits 28-31 come from four side inputs
// - sample clock from bus strobes, no qualification
// - reset selects one sample per bus cycle
// - trigger word has spare, status, address, data
// - muxed bus: fetch 0011, read 0010, write 0001
// - muxed i/o 0110/0101; controller i/o X1XX
// - interrupt acknowledge recorded as 0111
// - bit 27 carries hold grant, 1XXX
// - controllers: fetch X011, read X010, write X001
// - controller bits: write, read, expander strobes
// - switch picks write edge: phase-two or enable
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
module pcp_capture_pod
  import pcp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [pcp_pkg::REG_AW-1:0] reg_addr,
  input wire logic [pcp_pkg::WORD_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pcp_pkg::WORD_W-1:0] reg_rdata,
  // target data and address pins
  input wire logic [7:0] ad_in,
  input wire logic [15:0] addr_in,
  // multiplexed bus and controller strobes
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic inta_n_in,
  input wire logic cycle_status_low,
  input wire logic cycle_status_high,
  input wire logic io_mem_in,
  input wire logic hold_grant_out,
  input wire logic program_store_strobe_n,
  input wire logic expander_strobe_n,
  // clockless variant pins
  input wire logic data_bus_enable_in,
  input wire logic phi2_in,
  input wire logic rw_in,
  input wire logic halt_in,
  input wire logic vma_in,
  input wire logic ba_in,
  // side probe inputs
  input wire logic [3:0] spare_in,
  // capture output
  output logic [pcp_pkg::WORD_W-1:0] sample_word,
  output logic sample_valid,
  output logic trigger_hit
);
  import pcp_pkg::*;

  // ---------------------------------------------------------------
  // pin gathering and synchronisation
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] pins;   // raw pin vector in package order
  assign pins = {spare_in, ba_in, vma_in, halt_in, rw_in, phi2_in, data_bus_enable_in,
                 expander_strobe_n, program_store_strobe_n, hold_grant_out, io_mem_in,
                 cycle_status_high, cycle_status_low, inta_n_in, wr_n_in, rd_n_in, ale_in,
                 addr_in, ad_in};

  pcp_pin_if pin_bus ();

  // every pin is asynchronous to ref_clk, so all pass the synchroniser
  pcp_pin_sync u_sync (
    .ref_clk (ref_clk),
    .rst (rst),
    .pins (pins),
    .pin_bus (pin_bus.sync_side)
  );

  wire [PIN_W-1:0] pn = pin_bus.now;    // current synchronised level
  wire [PIN_W-1:0] pp = pin_bus.prev;   // level one cycle before

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r;            // family, switch, mode, enables
  logic [WORD_W-1:0] trig_val_r;        // trigger compare word
  logic [WORD_W-1:0] trig_mask_r;       // 1 = bit takes part in compare
  logic [COUNT_W-1:0] count_r;          // samples taken, wraps
  logic [7:0] addr_lo_r;                // demultiplexed low address
  logic hit_r;                          // sticky trigger flag

  pcp_family_t fam;
  assign fam = pcp_family_t'(ctrl_r[CTRL_FAM_LSB +: 2]);
  wire wsel = ctrl_r[CTRL_WSEL];
  wire free_run = ctrl_r[CTRL_FREE];
  wire cap_en = ctrl_r[CTRL_CAP_EN];
  wire spare_en = ctrl_r[CTRL_SPARE_EN];
  wire is_ctl = (fam == PCP_FAM_CTL_EXP) || (fam == PCP_FAM_CTL);

  // ---------------------------------------------------------------
  // edges of the synchronised strobes
  // ---------------------------------------------------------------
  // a strobe ends on its rising edge; data is then still valid in pp
  wire rd_end = pn[PIN_RD_N] & ~pp[PIN_RD_N];
  wire wr_end = pn[PIN_WR_N] & ~pp[PIN_WR_N];
  wire inta_end = pn[PIN_INTA_N] & ~pp[PIN_INTA_N];
  wire pstore_end = pn[PIN_PSTORE_N] & ~pp[PIN_PSTORE_N];
  wire exp_end = pn[PIN_EXP_N] & ~pp[PIN_EXP_N];
  wire hold_rise = pn[PIN_HOLD] & ~pp[PIN_HOLD];
  wire ale_fall = ~pn[PIN_ALE] & pp[PIN_ALE];
  wire phi2_fall = ~pn[PIN_PHI2] & pp[PIN_PHI2];
  wire bus_en_fall = ~pn[PIN_BUS_EN] & pp[PIN_BUS_EN];

  // ---------------------------------------------------------------
  // derived sample clock, one event per bus cycle
  // ---------------------------------------------------------------
  // the strobes alone make the event; nothing qualifies it
  wire ev_mux = rd_end | wr_end | inta_end | hold_rise;
  wire ev_ctl = rd_end | wr_end | pstore_end | ((fam == PCP_FAM_CTL_EXP) & exp_end);
  // reads close on phase-two fall, writes on the edge the switch picks
  wire ev_nclk_rd = phi2_fall & pp[PIN_RW];
  wire ev_nclk_wr = ~pp[PIN_RW] & (wsel ? bus_en_fall : phi2_fall);
  wire ev_nclk = ev_nclk_rd | ev_nclk_wr;

  wire bus_event = (fam == PCP_FAM_MUX) ? ev_mux :
                   is_ctl ? ev_ctl : ev_nclk;
  // free-running mode is the user's override of the power-up setting
  wire capture = cap_en & (free_run | bus_event);

  // ---------------------------------------------------------------
  // status nibble per family
  // ---------------------------------------------------------------
  // muxed bus: hold grant, i/o-memory, status high and low
  // hold grant is taken after its rise, so the sample made by that rise reads 1XXX
  wire [3:0] stat_mux = {pn[PIN_HOLD], pp[PIN_IOM], pp[PIN_STAT_HI], pp[PIN_STAT_LO]};
  // controllers: program store strobe sets both low bits, so fetch is X011
  wire pstore_act = ~pp[PIN_PSTORE_N];
  wire exp_act = (fam == PCP_FAM_CTL_EXP) & ~pp[PIN_EXP_N];
  wire [3:0] stat_ctl = {1'b0, exp_act, ~pp[PIN_RD_N] | pstore_act, ~pp[PIN_WR_N] | pstore_act};
  // clockless variant: bus available, valid address, halt, read/write
  wire [3:0] stat_nclk = {pp[PIN_BA], pp[PIN_VMA], pp[PIN_HALT], pp[PIN_RW]};
  wire [3:0] stat_nib = (fam == PCP_FAM_MUX) ? stat_mux :
                        is_ctl ? stat_ctl : stat_nclk;

  // ---------------------------------------------------------------
  // address and data assembly
  // ---------------------------------------------------------------
  wire [15:0] addr_mux = {pp[PIN_A + 8 +: 8], addr_lo_r};
  // controllers only drive twelve address lines; the rest read zero
  wire [15:0] addr_ctl = {{(16 - CTL_ADDR_W){1'b0}}, pp[PIN_A + 8 +: CTL_ADDR_W - 8], addr_lo_r};
  wire [15:0] addr_nclk = pp[PIN_A +: 16];
  wire [15:0] addr = (fam == PCP_FAM_MUX) ? addr_mux :
                     is_ctl ? addr_ctl : addr_nclk;
  wire [7:0] data = pp[PIN_AD +: 8];
  wire [3:0] spare = spare_en ? pp[PIN_SPARE +: 4] : 4'h0;
  // one word, field order spare / status / address / data
  wire [WORD_W-1:0] word = {spare, stat_nib, addr, data};

  // trigger compare over the four fields at once
  wire trig_match = ((word ^ trig_val_r) & trig_mask_r) == 32'h0000_0000;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
  wire wr_status = reg_wr & (reg_addr == REG_STATUS);
  wire wr_tval = reg_wr & (reg_addr == REG_TRIG_VAL);
  wire wr_tmask = reg_wr & (reg_addr == REG_TRIG_MASK);
  wire wr_count = reg_wr & (reg_addr == REG_COUNT);
  // unmapped reads answer zero
  wire [WORD_W-1:0] rd_mux =
    (reg_addr == REG_CTRL) ? {{(WORD_W - CTRL_W){1'b0}}, ctrl_r} :
    (reg_addr == REG_STATUS) ? {{(WORD_W - 1){1'b0}}, hit_r} :
    (reg_addr == REG_SAMPLE) ? sample_word :
    (reg_addr == REG_TRIG_VAL) ? trig_val_r :
    (reg_addr == REG_TRIG_MASK) ? trig_mask_r :
    (reg_addr == REG_COUNT) ? {{(WORD_W - COUNT_W){1'b0}}, count_r} : 32'h0000_0000;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // reset lands in synchronous per-cycle capture, software may change it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= reg_wdata[CTRL_W-1:0];
    end
  end

  // trigger word fields are freely writable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trig_val_r <= TRIG_VAL_RST;
      trig_mask_r <= TRIG_MASK_RST;
    end else begin
      if (wr_tval) begin
        trig_val_r <= reg_wdata;
      end
      if (wr_tmask) begin
        trig_mask_r <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // address demultiplexer
  // ---------------------------------------------------------------
  // low address is latched when the latch enable falls
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_lo_r <= 8'h00;
    end else if (ale_fall) begin
      addr_lo_r <= pp[PIN_AD +: 8];
    end
  end

  // ---------------------------------------------------------------
  // sample register
  // ---------------------------------------------------------------
  // all 32 bits take the same edge so the fields stay coherent
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sample_word <= 32'h0000_0000;
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= capture;
      if (capture) begin
        sample_word <= word;
      end
    end
  end

  // sample counter; a software write presets it, a capture in the same cycle loses
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_r <= 16'h0000;
    end else if (wr_count) begin
      count_r <= reg_wdata[COUNT_W-1:0];
    end else if (capture) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // trigger flag
  // ---------------------------------------------------------------
  // write one to clear; a match in the same cycle wins so no hit is lost
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hit_r <= 1'b0;
    end else if (capture & trig_match) begin
      hit_r <= 1'b1;
    end else if (wr_status & reg_wdata[STAT_HIT]) begin
      hit_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  // data stands in the cycle after the strobe only, zero otherwise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
      trigger_hit <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
      trigger_hit <= capture & trig_match | hit_r & ~(wr_status & reg_wdata[STAT_HIT]);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_DATA_LANE: assert property (capture |=> sample_word[7:0] == $past(pp[7:0]))
    else $error("data byte not on sample bits 0-7");
  AST_CTL_ADDR: assert property (capture && is_ctl |=> sample_word[23:20] == 4'h0)
    else $error("controller sample uses address bits above 19");
  AST_SPARE: assert property (capture && spare_en |=> sample_word[31:28] == $past(pp[PIN_SPARE +: 4]))
    else $error("side inputs not on bits 28-31");
  AST_NO_QUAL: assert property (cap_en && bus_event |=> sample_valid)
    else $error("bus cycle did not produce a sample");
  AST_ONE_PER_CYCLE: assert property (!free_run && !bus_event |=> !sample_valid)
    else $error("sample taken without a bus cycle");
  AST_TRIG: assert property (sample_valid && ((sample_word ^ trig_val_r) & trig_mask_r) == 32'h0000_0000
                             && $stable(trig_val_r) && $stable(trig_mask_r) |-> trigger_hit)
    else $error("matching sample did not raise the trigger flag");
  AST_MUX_STATUS: assert property (capture && fam == PCP_FAM_MUX
                                   |=> sample_word[27:24] == $past(stat_mux))
    else $error("multiplexed bus status nibble wrong");
  AST_HOLD: assert property (capture && fam == PCP_FAM_MUX && pn[PIN_HOLD] |=> sample_word[27])
    else $error("hold grant not on bit 27");
  AST_CTL_FETCH: assert property (capture && is_ctl && !pp[PIN_PSTORE_N]
                                  |=> sample_word[25:24] == 2'b11 && !sample_word[27])
    else $error("controller fetch not encoded X011");
  AST_WEDGE: assert property (cap_en && !free_run && fam == PCP_FAM_NOCLK && wsel && !pp[PIN_RW]
                              && phi2_fall && !bus_en_fall |=> !sample_valid)
    else $error("write sampled on phase-two fall with enable edge selected");
  AST_COHERENT: assert property (sample_valid && !$past(wr_count) |-> count_r == $past(count_r) + 16'h0001)
    else $error("sample count out of step with samples");

  COV_MUX_CYCLE: cover property (capture && fam == PCP_FAM_MUX && rd_end);
  COV_CTL_FETCH: cover property (capture && is_ctl && pstore_end);
  COV_NOCLK_BUS_EN: cover property (capture && fam == PCP_FAM_NOCLK && wsel && bus_en_fall);
  COV_TRIG: cover property (capture && trig_match ##1 trigger_hit);

endmodule

// [verif/pcp_bus_model.sv]
// target processor bus model: muxed, controller and clockless bus cycles
`timescale 1ns/1ns
module pcp_bus_model (
  // clock
  input wire logic ref_clk,
  // data and address pins
  output logic [7:0] ad_in,
  output logic [15:0] addr_in,
  // muxed bus and controller strobes
  output logic ale_in,
  output logic rd_n_in,
  output logic wr_n_in,
  output logic inta_n_in,
  output logic program_store_strobe_n,
  output logic expander_strobe_n,
  // muxed bus status
  output logic cycle_status_low,
  output logic cycle_status_high,
  output logic io_mem_in,
  output logic hold_grant_out,
  // clockless variant pins
  output logic data_bus_enable_in,
  output logic phi2_in,
  output logic rw_in,
  output logic halt_in,
  output logic vma_in,
  output logic ba_in
);
  // {io/mem, s1, s0} per cycle kind: fetch, read, write, io read, io write, int ack
  localparam logic [2:0] ST [8] = '{3'h3, 3'h2, 3'h1, 3'h6, 3'h5, 3'h7, 3'h0, 3'h0};
  // idle pins: active-low strobes high, read/write high
  initial begin
    {ad_in, addr_in, ale_in, cycle_status_low, cycle_status_high, io_mem_in, hold_grant_out} = '0;
    {rd_n_in, wr_n_in, inta_n_in, program_store_strobe_n, expander_strobe_n, rw_in} = 6'h3F;
    {data_bus_enable_in, phi2_in, halt_in, vma_in, ba_in} = '0;
  end
  // each phase of a muxed cycle holds four clocks, above the three the pod needs to see a level
  task automatic gap(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one multiplexed-bus cycle; kinds 6 and 7 use the controller strobes
  task automatic cyc(input int k, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    ale_in <= 1'b1;
    ad_in <= a[7:0];
    addr_in <= a;
    {io_mem_in, cycle_status_high, cycle_status_low} <= ST[k];
    gap(4);
    ale_in <= 1'b0;
    gap(4);
    ad_in <= d;
    case (k)
      2, 4: wr_n_in <= 1'b0;
      5: inta_n_in <= 1'b0;
      6: program_store_strobe_n <= 1'b0;
      7: expander_strobe_n <= 1'b0;
      default: rd_n_in <= 1'b0;
    endcase
    gap(4);
    {rd_n_in, wr_n_in, inta_n_in, program_store_strobe_n, expander_strobe_n} <= 5'h1F;
    gap(4);
    // released bus has no pull: show the inverse rather than a stale value
    ad_in <= ~d;
    {io_mem_in, cycle_status_high, cycle_status_low} <= 3'h0;
  endtask
  // bus handed over for a while
  task automatic hold();
    @(posedge ref_clk);
    hold_grant_out <= 1'b1;
    gap(8);
    hold_grant_out <= 1'b0;
    gap(4);
  endtask
  // clockless cycle, first half: both clocks high, then bus enable falls
  task automatic clk_a(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {addr_in, ad_in, rw_in, vma_in, phi2_in, data_bus_enable_in} <= {a, d, w, 3'h7};
    gap(4);
    data_bus_enable_in <= 1'b0;
    gap(10);
  endtask
  // second half: phase two falls, then the bus is released
  task automatic clk_b();
    phi2_in <= 1'b0;
    gap(10);
    {vma_in, rw_in} <= 2'h1;
    ad_in <= ~ad_in;
  endtask
endmodule

// [verif/tb_top.sv]
// self-checking bench for the capture pod driven by the bus model
`timescale 1ns/1ns
module tb_top;
  import pcp_pkg::*;
  // -------------------------------------------------------------
  // signals, design and bus model
  // -------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] spare_in = 4'h0;
  wire logic [31:0] reg_rdata, sample_word;
  wire logic sample_valid, trigger_hit, ale_in, rd_n_in, wr_n_in, inta_n_in, cycle_status_low;
  wire logic cycle_status_high, io_mem_in, hold_grant_out, program_store_strobe_n, expander_strobe_n;
  wire logic data_bus_enable_in, phi2_in, rw_in, halt_in, vma_in, ba_in;
  wire logic [7:0] ad_in;
  wire logic [15:0] addr_in;
  logic [31:0] got [$];
  int mismatches = 0;
  int checked = 0;
  // expected status codes per kind, muxed bus and controller families
  localparam logic [3:0] MUX_ST [8] = '{4'h3, 4'h2, 4'h1, 4'h6, 4'h5, 4'h7, 4'h0, 4'h0};
  localparam logic [3:0] CTL_ST [8] = '{4'h0, 4'h2, 4'h1, 4'h0, 4'h0, 4'h0, 4'h3, 4'h4};
  pcp_capture_pod DUT (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ad_in, .addr_in,
    .ale_in, .rd_n_in, .wr_n_in, .inta_n_in, .cycle_status_low, .cycle_status_high, .io_mem_in, .hold_grant_out,
    .program_store_strobe_n, .expander_strobe_n, .data_bus_enable_in, .phi2_in, .rw_in, .halt_in, .vma_in,
    .ba_in, .spare_in, .sample_word, .sample_valid, .trigger_hit);
  pcp_bus_model bus (.ref_clk, .ad_in, .addr_in, .ale_in, .rd_n_in, .wr_n_in, .inta_n_in, .program_store_strobe_n,
    .expander_strobe_n, .cycle_status_low, .cycle_status_high, .io_mem_in, .hold_grant_out, .data_bus_enable_in,
    .phi2_in, .rw_in, .halt_in, .vma_in, .ba_in);
  always #2 ref_clk = ~ref_clk;
  // every sample word is queued at the cycle its valid pulse stands
  always @(posedge ref_clk) if (sample_valid === 1'b1) got.push_back(sample_word);
  // -------------------------------------------------------------
  // expectation, bus and compare tasks
  // -------------------------------------------------------------
  function automatic logic [31:0] exp_w(int fam, int k, logic [15:0] a, logic [7:0] d, logic [3:0] sp);
    // controllers only drive twelve address bits
    return {sp, (fam == 0) ? MUX_ST[k] : CTL_ST[k], (fam == 0) ? a : {4'h0, a[11:0]}, d};
  endfunction
  task automatic test_done();
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // register tasks are entered just after a rising edge, except the free-run control write, which follows a falling edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // one idle edge, so a following write never raises the strobe just lowered
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask
  // next queued sample, bounded wait; the extra edges let the hit flag settle
  task automatic take(output logic [31:0] w);
    int n;
    n = 0;
    while (got.size() == 0 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    if (got.size() == 0) begin
      mismatches++;
      test_done();
    end else begin
      w = got.pop_front();
      repeat (2) @(posedge ref_clk);
    end
  endtask
  // one random bus cycle of the given kind, checked against the whole word
  task automatic run(input int fam, input int k);
    logic [31:0] r;
    logic [31:0] w;
    r = $urandom;
    spare_in <= r[31:28];
    bus.cyc(k, r[15:0], r[23:16]);
    take(w);
    chk("bus word", exp_w(fam, k, r[15:0], r[23:16], r[31:28]), w);
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    logic [31:0] v, r;
    void'($urandom(32'h9d3d));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    got.delete();
    rd(REG_CTRL, v);
    chk("ctrl reset", 32'h0000_0030, v);
    rd(8'h18, v);
    chk("unmapped", 32'h0000_0000, v);
    wr(REG_COUNT, 32'h0000_0000);
    // every muxed code first, then random kinds
    for (int i = 0; i < 12; i++) run(0, (i < 6) ? i : int'($urandom_range(5)));
    chk("any hit", 32'h0000_0001, {31'h0, trigger_hit});
    bus.hold();
    take(v);
    chk("hold status", 32'h0000_0008, {28'h0, v[27:24]});
    rd(REG_COUNT, v);
    chk("sample count", 32'h0000_000D, v);
    // trigger on the status field alone: reads hit, writes do not
    wr(REG_TRIG_MASK, 32'h0F00_0000);
    wr(REG_TRIG_VAL, 32'h0200_0000);
    wr(REG_STATUS, 32'h0000_0001);
    run(0, 2);
    rd(REG_STATUS, v);
    chk("no hit", 32'h0000_0000, v);
    run(0, 1);
    rd(REG_STATUS, v);
    chk("hit", 32'h0000_0001, v);
    // controller families
    wr(REG_CTRL, 32'h0000_0032);
    for (int k = 0; k < 3; k++) run(2, (k == 2) ? 6 : k + 1);
    wr(REG_CTRL, 32'h0000_0031);
    run(1, 7);
    // clockless: write on phase two, write on bus enable, then a read
    for (int s = 0; s < 3; s++) begin
      wr(REG_CTRL, (s == 1) ? 32'h0000_0037 : 32'h0000_0033);
      r = $urandom;
      bus.clk_a(s == 2, r[15:0], r[23:16]);
      @(negedge ref_clk);
      chk("early edge", (s == 1) ? 32'h1 : 32'h0, 32'(got.size()));
      @(posedge ref_clk);
      bus.clk_b();
      take(v);
      chk("clockless word", {spare_in, 3'h2, s == 2, r[15:0], r[23:16]}, v);
    end
    // capture switched off: bus cycles leave no sample
    wr(REG_CTRL, 32'h0000_0020);
    bus.cyc(1, 16'h1234, 8'h56);
    repeat (10) @(negedge ref_clk);
    chk("capture off", 32'h0000_0000, 32'(got.size()));
    // free run: one sample on every reference clock
    wr(REG_CTRL, 32'h0000_0038);
    repeat (6) @(negedge ref_clk);
    got.delete();
    repeat (10) @(negedge ref_clk);
    chk("free run", 32'h0000_000A, 32'(got.size()));
    test_done();
  end
endmodule
